//--- src/cpa_pkg.sv
// Purpose: Shared constants and types for the card adapter power and index access block.
// Assumes: Indexes are 8 bits; socket B registers sit at socket A index plus SOCK_B_OFS.
// Notes:   Reset values below are loaded by a synchronous, active-low reset.
package cpa_pkg;
  localparam logic [7:0] IX_PWR     = 8'h02;
  localparam logic [7:0] IX_CSC_STS = 8'h04;
  localparam logic [7:0] IX_CSC_EN  = 8'h05;
  localparam logic [7:0] IX_TSEL    = 8'h06;
  localparam logic [7:0] IX_PMC     = 8'h1E;
  localparam logic [7:0] IX_XIDX    = 8'h2E;
  localparam logic [7:0] IX_XDAT    = 8'h2F;
  localparam logic [7:0] IX_TSET0   = 8'h3A;
  localparam logic [7:0] IX_TSET1   = 8'h3D;
  localparam logic [7:0] SOCK_B_OFS = 8'h40;
  localparam logic [7:0] XI_EXTCFG  = 8'h03;
  localparam logic [7:0] XI_VSENSE  = 8'h0A;
  localparam int PMC_LPD_BIT  = 1;
  localparam int PMC_SUSP_BIT = 2;
  localparam int PWR_VCC_BIT  = 4;
  localparam int PWR_AUTO_BIT = 5;
  localparam int EXT_KEEP_BIT = 1;
  localparam int CSC_CD_BIT   = 3;
  localparam logic [7:0] PMC_RST = 8'h02;
  localparam logic [7:0] PMC_MSK = 8'h06;
  localparam int FIFO_DEPTH = 4;
  localparam int CARD_DW    = 32;

  typedef enum logic [2:0] {
    ST_ACT  = 3'b001,
    ST_GATE = 3'b010,
    ST_SUSP = 3'b100
  } cpa_pm_t;

  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] cmd;
    logic [7:0] recov;
  } cpa_tmg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       sel;
    logic [7:0] wdata;
  } cpa_io_t;

  typedef struct packed {
    logic               sock;
    logic [CARD_DW-1:0] data;
  } cpa_cw_t;

  typedef struct packed {
    cpa_pm_t             st;
    logic [7:0]          idx;
    logic [7:0]          xidx;
    logic [7:0]          pmc;
    logic [7:0]          extcfg;
    logic [7:0]          rdata;
    logic [1:0][7:0]     pwr;
    logic [1:0][7:0]     csc_en;
    logic [1:0][7:0]     tsel;
    logic [1:0]          sts;
    logic [1:0]          pres;
    logic [1:0]          vcc;
    logic [1:0]          vpp;
    logic [1:0]          irq;
    logic                mirq;
    logic [1:0][1:0]     cd1;
    logic [1:0][1:0]     cd2;
    logic [3:0]          vs1;
    logic [3:0]          vs2;
    logic                act1;
    logic                act2;
    logic [1:0]          ir1;
    logic [1:0]          ir2;
    logic [1:0][23:0]    tset;
    cpa_tmg_t            tmg;
  } cpa_core_st_t;
endpackage

//--- src/cpa_wfifo.sv
// Purpose: Write buffer between the host side and one card socket.
// Assumes: DEPTH is a power of two; both sides run on clock.
// Notes:   Storage is flip-flops; out_data is the entry at the read pointer.
`timescale 1ns/1ps
module cpa_wfifo #(
  parameter int W     = 32,
  parameter int DEPTH = 4
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data,
  output      logic         empty
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } cpa_wf_st_t;

  cpa_wf_st_t q;
  cpa_wf_st_t d;
  logic       push;
  logic       pop;

  assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign empty     = (q.cnt == '0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (!nrst) begin
      d = '0;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end
endmodule

//--- src/cpa_core.sv
// Purpose: Power modes, socket supply control, write buffering and indexed
//          register access of a dual-socket host-to-card adapter.
// Assumes: Host strobes and card write drain come from logic on clock;
//          card detect, voltage sense, card activity and card interrupts are pins.
// Notes:   Supplies follow card presence in both power modes.
// Summary of operation
// - Reset selects idle gating; bit1 zero disables.
// - Idle gating stops clock, holds card lines.
// - Activity wakes gated device, then regates automatically.
// - Bit2 one suspends; only bit2 zero resumes.
// - Suspend honours only index and mode writes.
// - Suspended device ignores all socket accesses.
// - Card interrupts still pass during suspend.
// - Removal clears supply enable unless keep bit.
// - No socket power after reset or absent.
// - Card present only when both detects low.
// - Auto power when supply bit 4 set; bit 5 ignored.
// - Insertion and removal raise management interrupt.
// - Two four-word write buffers, stall when full or gated.
// - Card writes are 32 bits; register accesses are 8 bits.
// - Two timing sets, chosen per window.
// - Voltage sense at extended 0Ah via 6Fh.
// - Index byte selects, data byte accesses.
// - Extended index 2Eh, extended data 2Fh.
// - Reset returns every register to default.
// - Socket B index is socket A plus 40h.
`timescale 1ns/1ps
module cpa_core #(
  parameter int DEPTH = cpa_pkg::FIFO_DEPTH
) (
  input  wire logic                           clock,
  input  wire logic                           nrst,
  input  wire cpa_pkg::cpa_io_t               io,
  output      logic [7:0]                     io_rdata,
  input  wire logic                           cw_valid,
  input  wire cpa_pkg::cpa_cw_t               cw,
  output      logic                           cw_ready,
  output      logic [1:0]                     card_wvalid,
  output      logic [1:0][cpa_pkg::CARD_DW-1:0] card_wdata,
  input  wire logic [1:0]                     card_wready,
  output      logic [1:0]                     fifo_empty,
  input  wire logic                           card_bus_act,
  input  wire logic [1:0][1:0]                cd_n,
  input  wire logic [3:0]                     vsense,
  input  wire logic [1:0]                     card_irq_in,
  output      logic [1:0]                     card_irq_out,
  output      logic                           mgmt_irq,
  output      logic [1:0]                     vcc_en,
  output      logic [1:0]                     vpp_en,
  output      logic                           core_clk_en,
  output      logic                           card_hold,
  input  wire logic                           tmg_sock,
  input  wire logic [2:0]                     tmg_win,
  output      cpa_pkg::cpa_tmg_t              tmg
);
  import cpa_pkg::*;

  cpa_core_st_t q;
  cpa_core_st_t d;
  logic [1:0]   present;
  logic [1:0]   ins;
  logic [1:0]   rem;
  logic [1:0]   in_v;
  logic [1:0]   in_r;
  logic [1:0]   out_r;
  logic         susp;
  logic         activity;
  logic         dwr;
  logic         drd;
  logic         s;
  logic [7:0]   base;

  // Per-socket registers decode on the socket A index; bit 6 picks the socket.
  function automatic logic [7:0] sock_base(input logic [7:0] ix);
    return ix & ~SOCK_B_OFS;
  endfunction

  function automatic logic tset_hit(input logic [7:0] ix, input logic [7:0] b);
    return (ix >= b) && (ix < b + 8'h03);
  endfunction

  assign susp = (q.st == ST_SUSP);
  assign dwr  = io.wr && io.sel;
  assign drd  = io.rd && io.sel;
  assign s    = q.idx[6];
  assign base = sock_base(q.idx);

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      present[k] = (q.cd2[k] == 2'b00);
      ins[k]     = present[k] && !q.pres[k];
      rem[k]     = !present[k] && q.pres[k];
    end
  end

  // A buffer that still holds data counts as activity so it drains before gating.
  assign activity = q.act2 || io.wr || io.rd || cw_valid || (|ins) || (|rem)
                    || !(&fifo_empty);

  generate
    for (genvar g = 0; g < 2; g++) begin : g_sock
      // Suspended writes are taken and dropped, so the host bus never hangs.
      assign in_v[g]  = cw_valid && (cw.sock == g) && (q.st == ST_ACT);
      assign out_r[g] = card_wready[g] && (q.st == ST_ACT);
      cpa_wfifo #(
        .W     (CARD_DW),
        .DEPTH (DEPTH)
      ) u_wfifo (
        .clock     (clock),
        .nrst      (nrst),
        .in_valid  (in_v[g]),
        .in_ready  (in_r[g]),
        .in_data   (cw.data),
        .out_valid (card_wvalid[g]),
        .out_ready (out_r[g]),
        .out_data  (card_wdata[g]),
        .empty     (fifo_empty[g])
      );
    end
  endgenerate

  assign cw_ready = susp || ((q.st == ST_ACT) && in_r[cw.sock]);

  always_comb begin
    d = q;
    d.cd1  = cd_n;
    d.cd2  = q.cd1;
    d.vs1  = vsense;
    d.vs2  = q.vs1;
    d.act1 = card_bus_act;
    d.act2 = q.act1;
    d.ir1  = card_irq_in;
    d.ir2  = q.ir1;
    d.pres = present;
    d.irq  = q.ir2;
    if (io.wr && !io.sel) begin
      d.idx = io.wdata;
    end
    if (dwr && (q.idx == IX_PMC)) begin
      d.pmc = io.wdata & PMC_MSK;
    end else if (dwr && !susp) begin
      if (base == IX_PWR) begin
        d.pwr[s] = io.wdata;
      end
      if (base == IX_CSC_EN) begin
        d.csc_en[s] = io.wdata;
      end
      if (base == IX_TSEL) begin
        d.tsel[s] = io.wdata;
      end
      if (base == IX_XIDX) begin
        d.xidx = io.wdata;
      end
      if ((base == IX_XDAT) && (q.xidx == XI_EXTCFG)) begin
        d.extcfg = io.wdata;
      end
      for (int k = 0; k < 2; k++) begin
        for (int f = 0; f < 3; f++) begin
          if (q.idx == ((k == 0 ? IX_TSET0 : IX_TSET1) + 8'(f))) begin
            d.tset[k][8*(2-f) +: 8] = io.wdata;
          end
        end
      end
    end
    if (io.rd && !io.sel) begin
      d.rdata = q.idx;
    end else if (drd) begin
      d.rdata = 8'h00;
      if (!susp) begin
        if (base == IX_PWR) begin
          d.rdata = q.pwr[s];
        end
        if (base == IX_CSC_STS) begin
          d.rdata = {4'h0, q.sts[s], 3'h0};
        end
        if (base == IX_CSC_EN) begin
          d.rdata = q.csc_en[s];
        end
        if (base == IX_TSEL) begin
          d.rdata = q.tsel[s];
        end
        if (base == IX_XIDX) begin
          d.rdata = q.xidx;
        end
        if ((base == IX_XDAT) && (q.xidx == XI_EXTCFG)) begin
          d.rdata = q.extcfg;
        end
        if ((base == IX_XDAT) && (q.xidx == XI_VSENSE)) begin
          d.rdata = {4'h0, q.vs2};
        end
        if (q.idx == IX_PMC) begin
          d.rdata = q.pmc;
        end
        if (tset_hit(q.idx, IX_TSET0)) begin
          d.rdata = q.tset[0][8*(2-int'(q.idx-IX_TSET0)) +: 8];
        end
        if (tset_hit(q.idx, IX_TSET1)) begin
          d.rdata = q.tset[1][8*(2-int'(q.idx-IX_TSET1)) +: 8];
        end
      end
    end
    for (int k = 0; k < 2; k++) begin
      // A card change in the cycle of the clearing read still sets the flag.
      if (drd && !susp && (base == IX_CSC_STS) && (s == k)) begin
        d.sts[k] = 1'b0;
      end
      if (ins[k] || rem[k]) begin
        d.sts[k] = 1'b1;
      end
      if (rem[k] && !q.extcfg[EXT_KEEP_BIT]) begin
        d.pwr[k][PWR_VCC_BIT] = 1'b0;
      end
      // Manual and automatic modes both gate supplies on card presence.
      d.vcc[k] = present[k] && d.pwr[k][PWR_VCC_BIT];
      d.vpp[k] = d.vcc[k] && (d.pwr[k][1:0] != 2'b00);
    end
    d.mirq = |(d.sts & {d.csc_en[1][CSC_CD_BIT], d.csc_en[0][CSC_CD_BIT]});
    d.tmg = q.tsel[tmg_sock][tmg_win] ? cpa_tmg_t'(q.tset[1])
                                      : cpa_tmg_t'(q.tset[0]);
    unique case (q.st)
      ST_ACT: begin
        if (q.pmc[PMC_SUSP_BIT]) begin
          d.st = ST_SUSP;
        end else if (q.pmc[PMC_LPD_BIT] && !activity) begin
          d.st = ST_GATE;
        end
      end
      ST_GATE: begin
        if (q.pmc[PMC_SUSP_BIT]) begin
          d.st = ST_SUSP;
        end else if (activity || !q.pmc[PMC_LPD_BIT]) begin
          d.st = ST_ACT;
        end
      end
      ST_SUSP: begin
        if (!q.pmc[PMC_SUSP_BIT]) begin
          d.st = ST_ACT;
        end
      end
      default: begin
        d.st = ST_ACT;
      end
    endcase
    if (!nrst) begin
      d     = '0;
      d.st  = ST_ACT;
      d.pmc = PMC_RST;
      // Detect pins are active low, so the synchronisers reset to the card-absent level.
      d.cd1 = '1;
      d.cd2 = '1;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  assign io_rdata     = q.rdata;
  assign card_irq_out = q.irq;
  assign mgmt_irq     = q.mirq;
  assign vcc_en       = q.vcc;
  assign vpp_en       = q.vpp;
  assign core_clk_en  = (q.st == ST_ACT);
  assign card_hold    = (q.st != ST_ACT);
  assign tmg          = q.tmg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_susp_wr;
    dwr && (q.idx == IX_PMC) && io.wdata[PMC_SUSP_BIT];
  endsequence

  sequence s_quiet_act;
    (q.st == ST_ACT) && q.pmc[PMC_LPD_BIT] && !q.pmc[PMC_SUSP_BIT] && !activity;
  endsequence

  sequence s_card_removed;
    rem[0] && !dwr;
  endsequence

  chk_reset_mode: assert property ($past(!nrst) |-> q.pmc == PMC_RST && q.st == ST_ACT)
    else $error("Mode after reset wrong.");
  chk_susp_entry: assert property (s_susp_wr |=> q.pmc[PMC_SUSP_BIT] ##1 q.st == ST_SUSP)
    else $error("Suspend not entered.");
  chk_susp_hold: assert property (susp && q.pmc[PMC_SUSP_BIT] |=> susp)
    else $error("Suspend left while bit set.");
  chk_idle_gate: assert property (s_quiet_act |=> q.st == ST_GATE ##0 !core_clk_en)
    else $error("Idle device not gated.");
  chk_gate_wake: assert property ((q.st == ST_GATE) && activity && !q.pmc[PMC_SUSP_BIT]
                                  |=> core_clk_en)
    else $error("Gated device did not wake.");
  chk_susp_drop: assert property (susp |-> !(|in_v) && cw_ready)
    else $error("Socket write taken in suspend.");
  chk_susp_reg: assert property (susp && dwr && (base == IX_PWR) && (q.idx != IX_PMC)
                                 |=> $stable(q.pwr))
    else $error("Register written in suspend.");
  chk_irq_pass: assert property (susp |=> card_irq_out == $past(q.ir2))
    else $error("Interrupt not passed in suspend.");
  chk_remove_off: assert property (rem[0] && !q.extcfg[EXT_KEEP_BIT]
                                   |=> !q.pwr[0][PWR_VCC_BIT] && !vcc_en[0])
    else $error("Supply kept after removal.");
  chk_absent_off: assert property (!q.pres[1] |-> !vcc_en[1] && !vpp_en[1])
    else $error("Supply on without card.");
  chk_auto_power: assert property (ins[0] && q.pwr[0][PWR_VCC_BIT] && q.pwr[0][PWR_AUTO_BIT]
                                   && !dwr |=> vcc_en[0])
    else $error("Auto power did not enable.");
  chk_ins_irq: assert property (ins[0] && q.csc_en[0][CSC_CD_BIT] && !dwr
                                |=> mgmt_irq ##1 (mgmt_irq || $past(drd || dwr)))
    else $error("No interrupt on insertion.");
  chk_index_wr: assert property (io.wr && !io.sel |=> q.idx == $past(io.wdata))
    else $error("Index not taken.");

  // Extended and socket B registers.
  chk_xidx_wr: assert property (dwr && !susp && (base == IX_XIDX)
                                |=> q.xidx == $past(io.wdata))
    else $error("Extended index not taken.");
  chk_ext_wr: assert property (dwr && !susp && (base == IX_XDAT)
                               && (q.xidx == XI_EXTCFG) |=> q.extcfg == $past(io.wdata))
    else $error("Extended config not taken.");
  chk_vsense_rd: assert property (drd && !susp && (base == IX_XDAT)
                                  && (q.xidx == XI_VSENSE)
                                  |=> io_rdata == {4'h0, $past(q.vs2)})
    else $error("Voltage sense read wrong.");
  chk_sock_b_wr: assert property (dwr && !susp && (q.idx == (IX_TSEL | SOCK_B_OFS))
                                  |=> q.tsel[1] == $past(io.wdata))
    else $error("Socket B register not taken.");

  // Card detect, supply and status behaviour.
  chk_absent_sock_a: assert property (!q.pres[0] |-> !vcc_en[0] && !vpp_en[0])
    else $error("Supply on without card.");
  chk_detect_both: assert property (q.pres[0] |-> $past(cd_n[0], 3) == 2'b00)
    else $error("Card seen without both detects.");
  chk_rem_irq: assert property (s_card_removed ##0 q.csc_en[0][CSC_CD_BIT]
                                |=> mgmt_irq)
    else $error("No interrupt on removal.");
  chk_keep_supply: assert property (s_card_removed ##0 q.extcfg[EXT_KEEP_BIT]
                                    |=> $stable(q.pwr[0][PWR_VCC_BIT]))
    else $error("Supply enable cleared despite keep.");
  chk_reset_supply: assert property ($past(!nrst)
                                     |-> vcc_en == 2'b00 && vpp_en == 2'b00 && !mgmt_irq)
    else $error("Supply or interrupt on after reset.");

  // Power mode and buffer behaviour.
  chk_susp_rd: assert property (susp && drd |=> io_rdata == 8'h00)
    else $error("Register read in suspend.");
  chk_buf_accept: assert property (cw_valid && (q.st == ST_ACT) && fifo_empty[cw.sock]
                                   |-> cw_ready)
    else $error("Empty buffer refused a write.");
endmodule

//--- verification/cpa_card_model.sv
// Purpose: Card-side stand-in that drains the write buffers and drives the socket pins.
// Assumes: A det bit high means the card grounds that detect pin.
// Notes:   Stall holds off the drain so the device buffers can be filled.
`timescale 1ns/1ps
module cpa_card_model #(
  parameter logic [3:0] VS_LVL = 4'h9
) (
  input  wire logic            clock,
  input  wire logic            stall,
  input  wire logic [1:0][1:0] det,
  input  wire logic [1:0]      irq,
  input  wire logic [1:0]      card_wvalid,
  output      logic [1:0]      card_wready,
  output      logic [1:0][1:0] cd_n,
  output      logic [3:0]      vsense,
  output      logic [1:0]      card_irq_in,
  output      logic [7:0]      n_drained
);
  logic [7:0] drained_q = 8'h00;
  assign n_drained   = drained_q;
  assign card_wready = {2{~stall}};
  assign cd_n        = ~det;
  assign vsense      = VS_LVL;
  assign card_irq_in = irq;
  // A word counts as taken only when the device offers it while the drain is open.
  always @(posedge clock) begin
    drained_q <= drained_q + 8'(card_wvalid[0] & card_wready[0])
                           + 8'(card_wvalid[1] & card_wready[1]);
  end
endmodule

//--- verification/tb.sv
// Purpose: Self-checking bench for the power, supply, buffer and index logic.
// Assumes: Host strobes and pins are driven by non-blocking assignment at rising edges.
// Notes:   Settling waits follow the synchroniser latencies of the design.
`timescale 1ns/1ps
module tb;
  import cpa_pkg::*;
  localparam logic [3:0] VS_LVL = 4'h9;
  logic                  clock = 1'b0;
  logic                  nrst;
  cpa_io_t               io;
  logic [7:0]            io_rdata;
  logic                  cw_valid;
  cpa_cw_t               cw;
  logic                  cw_ready;
  logic [1:0]            card_wvalid;
  logic [1:0][31:0]      card_wdata;
  logic [1:0]            card_wready;
  logic [1:0]            fifo_empty;
  logic                  card_bus_act;
  logic [1:0][1:0]       cd_n;
  logic [3:0]            vsense;
  logic [1:0]            card_irq_in;
  logic [1:0]            card_irq_out;
  logic                  mgmt_irq;
  logic [1:0]            vcc_en;
  logic [1:0]            vpp_en;
  logic                  core_clk_en;
  logic                  card_hold;
  logic                  tmg_sock;
  logic [2:0]            tmg_win;
  cpa_tmg_t              tmg;
  logic                  stall;
  logic [1:0][1:0]       det;
  logic [1:0]            irq;
  logic [7:0]            n_drained;
  int                    n_mismatch = 0;
  int                    num_checks = 0;

  always #12.5 clock = ~clock;

  cpa_core cpa_core_inst (.clock, .nrst, .io, .io_rdata, .cw_valid, .cw, .cw_ready,
    .card_wvalid, .card_wdata, .card_wready, .fifo_empty, .card_bus_act, .cd_n, .vsense,
    .card_irq_in, .card_irq_out, .mgmt_irq, .vcc_en, .vpp_en, .core_clk_en, .card_hold,
    .tmg_sock, .tmg_win, .tmg);
  cpa_card_model #(.VS_LVL(VS_LVL)) cpa_card_model_inst (.clock, .stall, .det, .irq,
    .card_wvalid, .card_wready, .cd_n, .vsense, .card_irq_in, .n_drained);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge clock);
    io <= '{wr: 1'b1, rd: 1'b0, sel: sel, wdata: d};
    @(posedge clock);
    io <= '0;
  endtask
  task automatic wreg(input logic [7:0] ix, input logic [7:0] d);
    wr(1'b0, ix);
    wr(1'b1, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] ix, input logic [7:0] e);
    wr(1'b0, ix);
    @(posedge clock);
    io <= '{wr: 1'b0, rd: 1'b1, sel: 1'b1, wdata: 8'h00};
    @(posedge clock);
    io <= '0;
    @(posedge clock);
    #1;
    chk(nm, e, io_rdata);
  endtask
  task automatic push(input logic s, input logic [31:0] d, input logic e);
    logic ok;
    ok = 1'b0;
    @(posedge clock);
    cw_valid <= 1'b1;
    cw <= '{sock: s, data: d};
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = (cw_ready === 1'b1);
      @(posedge clock);
    end
    cw_valid <= 1'b0;
    chk("cw_ready", e, ok);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    io = '0;
    cw_valid = 1'b0;
    cw = '0;
    card_bus_act = 1'b0;
    tmg_sock = 1'b0;
    tmg_win = 3'h0;
    stall = 1'b0;
    det = '0;
    irq = 2'h0;
    wt(10);
    nrst <= 1'b1;
    wt(5);
    chk("clk_en", 1'b0, core_clk_en);
    chk("hold", 1'b1, card_hold);
    card_bus_act <= 1'b1;
    wt(5);
    chk("clk_en", 1'b1, core_clk_en);
    card_bus_act <= 1'b0;
    rchk("pmc", IX_PMC, 8'h02);
    wt(5);
    chk("clk_en", 1'b0, core_clk_en);
    rchk("pwr", IX_PWR, 8'h00);
    chk("vcc", 2'h0, vcc_en);
    wreg(IX_PMC, 8'h00);
    wt(4);
    chk("clk_en", 1'b1, core_clk_en);
    wreg(IX_TSET0, 8'h11);
    wreg(IX_TSET1, 8'h22);
    wreg(IX_TSEL, 8'h01);
    wreg(IX_TSEL + SOCK_B_OFS, 8'h02);
    rchk("tselA", IX_TSEL, 8'h01);
    rchk("tselB", IX_TSEL + SOCK_B_OFS, 8'h02);
    for (int i = 0; i < 4; i++) begin
      tmg_sock <= i[1];
      tmg_win <= 3'(i[0]);
      wt(3);
      chk("tmg", (i == 0 || i == 3) ? 32'h0022_0000 : 32'h0011_0000, tmg);
    end
    wr(1'b0, IX_XIDX + SOCK_B_OFS);
    wr(1'b1, XI_VSENSE);
    rchk("vsense", IX_XDAT + SOCK_B_OFS, {4'h0, VS_LVL});
    wreg(IX_PWR, 8'h31);
    wreg(IX_CSC_EN, 8'h08);
    det[0] <= 2'b01;
    wt(8);
    chk("vcc", 2'h0, vcc_en);
    chk("mirq", 1'b0, mgmt_irq);
    det[0] <= 2'b11;
    wt(8);
    chk("vcc", 2'h1, vcc_en);
    chk("vpp", 2'h1, vpp_en);
    chk("mirq", 1'b1, mgmt_irq);
    rchk("csc", IX_CSC_STS, 8'h08);
    wt(2);
    chk("mirq", 1'b0, mgmt_irq);
    det[0] <= 2'b00;
    wt(8);
    chk("vcc", 2'h0, vcc_en);
    chk("mirq", 1'b1, mgmt_irq);
    rchk("pwr", IX_PWR, 8'h21);
    wreg(IX_XIDX, XI_EXTCFG);
    wreg(IX_XDAT, 8'h02);
    wreg(IX_PWR, 8'h10);
    det[0] <= 2'b11;
    wt(8);
    chk("vcc", 2'h1, vcc_en);
    det[0] <= 2'b00;
    wt(8);
    rchk("pwr", IX_PWR, 8'h10);
    chk("vcc", 2'h0, vcc_en);
    stall <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) push(1'b0, 32'hA5C3_0000 + i, 1'b1);
    push(1'b1, 32'h5A3C_F00F, 1'b1);
    push(1'b0, 32'hDEAD_0001, 1'b0);
    chk("head", 32'hA5C3_0000, card_wdata[0]);
    chk("empty", 2'h0, fifo_empty);
    stall <= 1'b0;
    wt(8);
    chk("drained", 8'(FIFO_DEPTH + 1), n_drained);
    chk("empty", 2'h3, fifo_empty);
    wreg(IX_PWR, 8'h00);
    wreg(IX_PMC, 8'h04);
    wt(4);
    chk("clk_en", 1'b0, core_clk_en);
    rchk("susp_rd", IX_TSET0, 8'h00);
    wreg(IX_TSET0, 8'h33);
    wreg(IX_PWR, 8'h10);
    push(1'b0, 32'h1234_5678, 1'b1);
    wt(2);
    chk("empty", 2'h3, fifo_empty);
    irq <= 2'h1;
    wt(5);
    chk("irq_out", 2'h1, card_irq_out);
    wreg(IX_PMC, 8'h00);
    wt(4);
    chk("clk_en", 1'b1, core_clk_en);
    rchk("tset0", IX_TSET0, 8'h11);
    rchk("pwr_susp", IX_PWR, 8'h00);
    wt(1);
    nrst <= 1'b0;
    wt(3);
    nrst <= 1'b1;
    rchk("pmc_rst", IX_PMC, 8'h02);
    rchk("tset_rst", IX_TSET0, 8'h00);
    chk("vcc_rst", 2'h0, vcc_en);
    chk("mirq_rst", 1'b0, mgmt_irq);
    final_report();
  end
endmodule
